// *** hdl/scmc_ctrl.sv ***
// Serial command interpreter with its write-data FIFO.
`timescale 1ns/1ns
`default_nettype none

module scmc_fifo #(
   parameter int WIDTH = 27,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input  wire logic             sys_clk,
   input  wire logic             rst,
   // Filling side.
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side.
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   // Full and empty come straight from the occupancy count.
   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = mem[rdPtr_q];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;

   // Storage array has no reset; only occupied slots are ever read.
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // Pointers and count.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (push) begin
            wrPtr_q <= wrPtr_q + AW'(1);
         end
         if (pop) begin
            rdPtr_q <= rdPtr_q + AW'(1);
         end
         if (push && !pop) begin
            count_q <= count_q + (AW+1)'(1);
         end else if (pop && !push) begin
            count_q <= count_q - (AW+1)'(1);
         end
      end
   end
endmodule

module scmc_ctrl
   import scmc_pkg::*;
(
   // Clock and reset.
   input  wire logic                sys_clk,
   input  wire logic                rst,
   // Serial link from the host.
   input  wire logic                sclk,
   input  wire logic                din,
   output logic                     dout,
   // Read data source; rdData must follow rdTarget.
   output logic [2:0]               rdTarget,
   output logic                     rdStart,
   input  wire logic [WORD_W-1:0]   rdData,
   // Completed writes, target above data.
   output logic                     wrValid,
   input  wire logic                wrReady,
   output logic [FIFO_W-1:0]        wrWord,
   // Status.
   output logic                     contActive,
   output logic                     wrBusy
);
   typedef enum {ST_CMD, ST_WRITE, ST_READ, ST_CONT} scmc_state_t;

   scmc_state_t      state_q;
   logic [2:0]       sclkSync_q;
   logic [2:0]       dinSync_q;
   logic             sclkLvl_q;
   logic             rise;
   logic             fall;
   logic             bit_;
   logic [7:0]       cmd_q;
   logic [7:0]       cmdNext;
   logic [3:0]       cmdCnt_q;
   logic [2:0]       byteCnt_q;
   logic [4:0]       bitCnt_q;
   logic [4:0]       len_q;
   logic [WORD_W-1:0] inShift_q;
   logic [WORD_W-1:0] outShift_q;
   logic             loadPend_q;
   logic             dout_q;
   logic             rdStart_q;
   logic             pushValid_q;
   logic [FIFO_W-1:0] pushWord_q;
   logic             pushReady;
   logic             stall;
   logic [4:0]       newLen;

   // Three-stage synchronisers; a serial clock change counts when stages two and three agree.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclkSync_q <= 3'h0;
         dinSync_q  <= 3'h0;
      end else begin
         sclkSync_q <= {sclkSync_q[1:0], sclk};
         dinSync_q  <= {dinSync_q[1:0], din};
      end
   end

   // Filtered serial clock level for edge finding.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sclkLvl_q <= 1'b0;
      end else if (sclkSync_q[1] == sclkSync_q[2]) begin
         sclkLvl_q <= sclkSync_q[2];
      end
   end

   // A pending write the FIFO cannot take freezes the serial engine.
   assign stall   = pushValid_q && !pushReady;
   assign rise    = (sclkSync_q[1] == sclkSync_q[2]) && sclkSync_q[2] && !sclkLvl_q && !stall;
   assign fall    = (sclkSync_q[1] == sclkSync_q[2]) && !sclkSync_q[2] && sclkLvl_q && !stall;
   assign bit_    = dinSync_q[2];
   assign cmdNext = {cmd_q[6:0], bit_};
   assign newLen  = scmcLen(cmdNext[POS_TARGET_HI:0]);

   // Command decode and transfer sequencing on rising serial edges.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q    <= ST_CMD;
         cmd_q      <= CMD_RESET;
         cmdCnt_q   <= 4'h0;
         byteCnt_q  <= 3'h0;
         bitCnt_q   <= 5'h00;
         len_q      <= LEN_BYTE;
         rdTarget   <= TGT_COMMAND;
         inShift_q  <= WORD_RESET;
         loadPend_q <= 1'b0;
      end else if (rise) begin
         cmd_q <= cmdNext;
         case (state_q)
            ST_CMD: begin
               if (cmdCnt_q == 4'h0 && bit_) begin
                  cmdCnt_q <= 4'h0; // Gate bit high: hold at the first bit.
               end else if (cmdCnt_q != 4'(CMD_BITS - 1)) begin
                  cmdCnt_q <= cmdCnt_q + 4'h1;
               end else begin
                  cmdCnt_q <= 4'h0;
                  bitCnt_q <= 5'h00;
                  len_q    <= newLen;
                  // Clear old data so that a short write stays right-aligned with zeros above it.
                  inShift_q <= WORD_RESET;
                  rdTarget <= cmdNext[POS_TARGET_HI:0];
                  case (cmdNext[POS_MODE_HI:POS_MODE_LO])
                     MODE_WRITE: begin
                        // A write to the command target is simply the next command.
                        if (cmdNext[POS_TARGET_HI:0] != TGT_COMMAND) begin
                           state_q <= ST_WRITE;
                        end
                     end
                     MODE_READ: begin
                        state_q    <= ST_READ;
                        loadPend_q <= 1'b1;
                     end
                     MODE_CONT_START: begin
                        state_q    <= ST_CONT;
                        byteCnt_q  <= 3'h0;
                        loadPend_q <= 1'b1;
                     end
                     default: begin
                        state_q <= ST_CMD; // Stop outside continuous read is a no-op.
                     end
                  endcase
               end
            end
            ST_WRITE: begin
               inShift_q <= {inShift_q[WORD_W-2:0], bit_};
               bitCnt_q  <= bitCnt_q + 5'h01;
               if (bitCnt_q == len_q - 5'h01) begin
                  state_q <= ST_CMD;
               end
            end
            ST_READ: begin
               bitCnt_q <= bitCnt_q + 5'h01;
               if (bitCnt_q == len_q - 5'h01) begin
                  state_q <= ST_CMD;
               end
            end
            ST_CONT: begin
               // Data input is checked for the stop code at every eighth edge, on byte boundaries, while words stream out.
               byteCnt_q <= byteCnt_q + 3'h1;
               if (byteCnt_q == 3'h7 && cmdNext[7:4] == STOP_CODE[7:4]
                   && cmdNext[3:0] == LOW_NIBBLE_ZERO) begin
                  state_q <= ST_CMD;
               end else if (bitCnt_q == len_q - 5'h01) begin
                  bitCnt_q   <= 5'h00;
                  loadPend_q <= 1'b1; // Next transfer reads the same target.
               end else begin
                  bitCnt_q <= bitCnt_q + 5'h01;
               end
            end
            default: begin
               state_q <= ST_CMD;
            end
         endcase
      end else if (fall && loadPend_q) begin
         loadPend_q <= 1'b0;
      end
   end

   // Read shifter: loads on the falling edge after a read begins, shifts on the rest.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         outShift_q <= WORD_RESET;
         dout_q     <= 1'b0;
         rdStart_q  <= 1'b0;
      end else begin
         rdStart_q <= 1'b0;
         if (fall && (state_q == ST_READ || state_q == ST_CONT)) begin
            if (loadPend_q) begin
               outShift_q <= rdData << (5'(WORD_W) - len_q);
               dout_q     <= rdData[len_q - 5'h01];
               rdStart_q  <= 1'b1;
            end else begin
               outShift_q <= {outShift_q[WORD_W-2:0], 1'b0};
               dout_q     <= outShift_q[WORD_W-2];
            end
         end
      end
   end

   // Completed write words wait here until the FIFO accepts them.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pushValid_q <= 1'b0;
         pushWord_q  <= '0;
      end else if (rise && state_q == ST_WRITE && bitCnt_q == len_q - 5'h01) begin
         pushValid_q <= 1'b1;
         pushWord_q  <= {rdTarget, inShift_q[WORD_W-2:0], bit_};
      end else if (pushReady) begin
         pushValid_q <= 1'b0;
      end
   end

   scmc_fifo #(
      .WIDTH (FIFO_W),
      .DEPTH (FIFO_DEPTH)
   ) writeFifo (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .inValid  (pushValid_q),
      .inReady  (pushReady),
      .inData   (pushWord_q),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  (wrWord)
   );

   assign dout       = dout_q;
   assign rdStart    = rdStart_q;
   assign contActive = (state_q == ST_CONT);
   assign wrBusy     = stall;
endmodule

`default_nettype wire

// *** common/scmc_pkg.sv ***
// Constants and rule summary for the serial command mode control block.
package scmc_pkg;

   // Command byte layout.
   localparam int CMD_BITS      = 8;
   localparam int POS_MODE_HI   = 5;
   localparam int POS_MODE_LO   = 4;
   localparam int POS_TARGET_HI = 2;
   localparam logic [7:0] STOP_CODE = 8'h30;
   localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

   // Transfer mode encodings.
   localparam logic [1:0] MODE_WRITE      = 2'h0;
   localparam logic [1:0] MODE_READ       = 2'h1;
   localparam logic [1:0] MODE_CONT_START = 2'h2;
   localparam logic [1:0] MODE_CONT_STOP  = 2'h3;

   // Target codes.
   localparam logic [2:0] TGT_COMMAND = 3'h0;
   localparam logic [2:0] TGT_DATA    = 3'h1;
   localparam logic [2:0] TGT_MODE    = 3'h2;
   localparam logic [2:0] TGT_FILTER  = 3'h3;
   localparam logic [2:0] TGT_DAC     = 3'h4;
   localparam logic [2:0] TGT_OFFSET  = 3'h5;
   localparam logic [2:0] TGT_GAIN    = 3'h6;
   localparam logic [2:0] TGT_TEST    = 3'h7;

   // Data word geometry and FIFO shape.
   localparam int WORD_W     = 24;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W     = WORD_W + 3;
   localparam logic [4:0] LEN_BYTE = 5'h08;
   localparam logic [4:0] LEN_HALF = 5'h10;
   localparam logic [4:0] LEN_FULL = 5'h18;

   // Reset values.
   localparam logic [7:0]  CMD_RESET  = 8'h00;
   localparam logic [23:0] WORD_RESET = 24'h000000;

   // Transfer length in serial bits for a target; status and DAC are one byte.
   function automatic logic [4:0] scmcLen(input logic [2:0] tgt);
      case (tgt)
         TGT_COMMAND: scmcLen = LEN_BYTE;
         TGT_DAC:     scmcLen = LEN_BYTE;
         TGT_MODE:    scmcLen = LEN_HALF;
         default:     scmcLen = LEN_FULL;
      endcase
   endfunction

endpackage

// *** bench/scmc_ctrl_props.sv ***
// Checker that watches the command interpreter's ports.
`timescale 1ns/1ns
`default_nettype none
module scmc_ctrl_props
   import scmc_pkg::*;
(
   // Clock and reset.
   input wire logic              sys_clk,
   input wire logic              rst,
   // Observed ports.
   input wire logic [2:0]        rdTarget,
   input wire logic              rdStart,
   input wire logic              wrValid,
   input wire logic              wrReady,
   input wire logic [FIFO_W-1:0] wrWord,
   input wire logic              contActive,
   input wire logic              wrBusy
);
   // All checks live in the system clock domain and pause during reset.
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   reset_state_a: assert property (
      $fell(rst) |-> !contActive && !wrValid && rdTarget == 3'h0) else $error("bad reset state");
   read_pulse_a: assert property (
      rdStart |=> !rdStart) else $error("read load pulse too long");
   cont_load_a: assert property (
      $rose(contActive) |-> ##[1:40] rdStart) else $error("no word after continuous entry");
   head_hold_a: assert property (
      wrValid && !wrReady |=> wrValid && $stable(wrWord)) else $error("write head lost");
   stop_stays_a: assert property (
      $fell(contActive) |=> !contActive [*8]) else $error("continuous read came back");
   write_mode_a: assert property (
      $rose(wrValid) |-> !contActive) else $error("write during continuous read");
   cont_target_a: assert property (
      contActive && $past(contActive) |-> $stable(rdTarget)) else $error("target moved");
   busy_full_a: assert property (
      wrBusy |-> wrValid) else $error("busy with empty queue");
   // The main scenarios must be reached.
   cover property ($rose(contActive));
   cover property ($fell(contActive));
   cover property (wrBusy);
endmodule
bind scmc_ctrl scmc_ctrl_props i_scmc_ctrl_props (
   .sys_clk(sys_clk), .rst(rst), .rdTarget(rdTarget), .rdStart(rdStart),
   .wrValid(wrValid), .wrReady(wrReady), .wrWord(wrWord),
   .contActive(contActive), .wrBusy(wrBusy));
`default_nettype wire

// *** bench/scmc_host.sv ***
// Host model that clocks command and data bits over the serial link.
`timescale 1ns/1ns
`default_nettype none
module scmc_host (
   // Serial link pins.
   output logic      sclk,
   output logic      din,
   input  wire logic dout
);
   // The clock stands low outside frames.
   initial begin
      sclk = 1'b0;
      din  = 1'b0;
   end
   // Sends n bits of v MSB first and gathers the read bits in rx.
   task automatic xfer(input logic [23:0] v, input int n, output logic [23:0] rx);
      rx = 24'h0;
      for (int i = n - 1; i >= 0; i--) begin
         din = v[i];
         #80 sclk = 1'b1;
         rx = {rx[22:0], dout};
         #80 sclk = 1'b0;
      end
      // A released line must not keep showing the last bit.
      #80 din = ~din;
      // Let time pass so that the next frame does not drive din in the same step.
      #80;
   endtask
endmodule
`default_nettype wire

// *** bench/scmc_ctrl_tb_top.sv ***
// Self-checking bench for the serial command interpreter.
`timescale 1ns/1ns
`default_nettype none
module scmc_ctrl_tb_top;
   import scmc_pkg::*;
   logic              sys_clk = 1'b0;
   logic              rst = 1'b1;
   logic              wrReady = 1'b0;
   logic              sclk, din, dout, rdStart, wrValid, contActive, wrBusy;
   logic [2:0]        rdTarget;
   logic [WORD_W-1:0] rdData;
   logic [FIFO_W-1:0] wrWord;
   logic [23:0]       rx;
   int                fail_count = 0;
   int                checked = 0;
   int                cycles = 0;

   // Read source follows the target so each target yields its own word.
   assign rdData = 24'hA5C35A ^ {21'h0, rdTarget};

   scmc_ctrl i_scmc_ctrl (.sys_clk(sys_clk), .rst(rst), .sclk(sclk), .din(din), .dout(dout),
      .rdTarget(rdTarget), .rdStart(rdStart), .rdData(rdData), .wrValid(wrValid),
      .wrReady(wrReady), .wrWord(wrWord), .contActive(contActive), .wrBusy(wrBusy));
   scmc_host i_scmc_host (.sclk(sclk), .din(din), .dout(dout));

   // Clock and a watchdog that cuts a hang short.
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 30000) begin
         fail_count++;
         summarize();
      end
   end

   function automatic int lenOf(input logic [2:0] t);
      return (t == 3'h0 || t == 3'h4) ? 8 : (t == 3'h2) ? 16 : 24;
   endfunction
   function automatic logic [23:0] expRead(input logic [2:0] t);
      return (24'hA5C35A ^ {21'h0, t}) & ((24'h1 << lenOf(t)) - 24'h1);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Stray stop and command-target write first, then gate ones, then a 16-bit write.
   task automatic t_write();
      i_scmc_host.xfer(24'h30, 8, rx);
      chk(contActive, 1'b0);
      i_scmc_host.xfer(24'h00, 8, rx);
      chk(wrValid, 1'b0);
      i_scmc_host.xfer(24'h3, 2, rx);
      i_scmc_host.xfer(24'h02, 8, rx);
      i_scmc_host.xfer(24'hBEEF, 16, rx);
      repeat (2) @(negedge sys_clk);
      chk(wrValid, 1'b1);
      chk(wrWord, {3'h2, 8'h00, 16'hBEEF});
      wrReady = 1'b1;
      @(negedge sys_clk) wrReady = 1'b0;
      chk(wrValid, 1'b0);
      $display("t_write done");
   endtask
   // Single reads of every target, each followed by a fresh command.
   task automatic t_read();
      for (int t = 0; t < 8; t++) begin
         i_scmc_host.xfer({16'h0, 5'h02, t[2:0]}, 8, rx);
         i_scmc_host.xfer(24'h0, lenOf(t[2:0]), rx);
         chk(rx, expRead(t[2:0]));
         chk(contActive, 1'b0);
      end
      $display("t_read done");
   endtask
   // Continuous read with low data in whole bytes; a near-miss byte must not stop it.
   task automatic t_cont();
      i_scmc_host.xfer(24'h21, 8, rx);
      chk(contActive, 1'b1);
      for (int k = 0; k < 3; k++) begin
         i_scmc_host.xfer(24'h0, 24, rx);
         chk(rx, expRead(3'h1));
      end
      i_scmc_host.xfer(24'h31, 8, rx);
      chk(contActive, 1'b1);
      i_scmc_host.xfer(24'h30, 8, rx);
      chk(contActive, 1'b0);
      $display("t_cont done");
   endtask
   // Reset in mid continuous read, then a single read shows that the engine restarted.
   task automatic t_reset();
      i_scmc_host.xfer(24'h21, 8, rx);
      chk(contActive, 1'b1);
      @(negedge sys_clk) rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk({contActive, wrValid, rdTarget}, 5'h00);
      i_scmc_host.xfer(24'h11, 8, rx);
      i_scmc_host.xfer(24'h0, 24, rx);
      chk(rx, expRead(3'h1));
      chk(contActive, 1'b0);
      $display("t_reset done");
   endtask
   // Seventeen writes against a stalled consumer, then a full drain in order.
   task automatic t_fifo();
      for (int k = 0; k < 17; k++) begin
         i_scmc_host.xfer(24'h04, 8, rx);
         i_scmc_host.xfer(24'(k), 8, rx);
      end
      @(negedge sys_clk);
      chk(wrBusy, 1'b1);
      wrReady = 1'b1;
      for (int k = 0; k < 17; k++) begin
         chk(wrWord, {3'h4, 16'h0, k[7:0]});
         @(negedge sys_clk);
      end
      wrReady = 1'b0;
      chk(wrValid, 1'b0);
      $display("t_fifo done");
   endtask

   // Reset, then the scenarios in turn.
   initial begin
      repeat (10) @(negedge sys_clk);
      rst = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk({contActive, wrValid, rdTarget}, 5'h00);
      t_write();
      t_read();
      t_cont();
      t_reset();
      t_fifo();
      summarize();
   end
endmodule
`default_nettype wire
